// file: rtl/mie_exec.sv
// decode and execute of literal load, subtract, nibble exchange, direction load
`timescale 1ns/1ps
`default_nettype none
module mie_exec #(
	parameter int DATA_W = mie_pkg::DATA_W
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rst_n,
	input  wire logic                         clk_en,
	input  wire logic                         insn_valid,
	input  wire logic [mie_pkg::INSN_W-1:0]   insn,
	input  wire logic [DATA_W-1:0]            file_operand,
	output logic      [DATA_W-1:0]            acc,
	output logic                              flag_carry,
	output logic                              flag_digit_carry,
	output logic                              flag_zero,
	output logic                              file_wr_en,
	output logic      [mie_pkg::FADDR_W-1:0]  file_wr_addr,
	output logic      [DATA_W-1:0]            file_wr_data,
	output logic                              dir_wr_en,
	output logic      [mie_pkg::DSEL_W-1:0]   dir_wr_sel,
	output logic      [DATA_W-1:0]            dir_wr_data,
	output logic                              insn_unhandled
);
	typedef struct packed {
		logic [DATA_W-1:0]           acc;
		logic                        c;
		logic                        dc;
		logic                        z;
		logic                        fwe;
		logic [mie_pkg::FADDR_W-1:0] faddr;
		logic [DATA_W-1:0]           fdata;
		logic                        dwe;
		logic [mie_pkg::DSEL_W-1:0]  dsel;
		logic [DATA_W-1:0]           ddata;
		logic                        unh;
	} mie_state_t;

	mie_state_t st_r;
	mie_state_t st_nxt;

	// result in low bits, then zero, digit carry, carry on top
	function automatic logic [DATA_W+2:0] mie_sub(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] w);
		logic [DATA_W:0] sum;
		logic [mie_pkg::NIB_MID:0] lo;
		sum = {1'b0, f} + {1'b0, ~w} + {{DATA_W{1'b0}}, 1'b1};
		lo  = {1'b0, f[mie_pkg::NIB_LO:0]} + {1'b0, ~w[mie_pkg::NIB_LO:0]} + {{mie_pkg::NIB_MID{1'b0}}, 1'b1};
		// carry out of the complement add means no borrow
		return {sum[DATA_W], lo[mie_pkg::NIB_MID], (sum[DATA_W-1:0] == '0), sum[DATA_W-1:0]};
	endfunction

	function automatic logic [DATA_W-1:0] mie_swap(input logic [DATA_W-1:0] f);
		return {f[mie_pkg::NIB_LO:0], f[mie_pkg::NIB_HI:mie_pkg::NIB_MID]};
	endfunction

	logic                 is_lit;
	logic                 is_sub;
	logic                 is_swap;
	logic                 is_dir;
	logic                 dest;
	logic [DATA_W+2:0]    sub_res;
	logic [DATA_W-1:0]    swp;

	assign is_lit  = insn[mie_pkg::TOP4_HI:mie_pkg::TOP4_LO] == mie_pkg::OPC_LOAD_LIT;
	assign is_sub  = insn[mie_pkg::TOP4_HI:mie_pkg::TOP6_LO] == mie_pkg::OPC_SUB_ACC;
	assign is_swap = insn[mie_pkg::TOP4_HI:mie_pkg::TOP6_LO] == mie_pkg::OPC_NIB_EXCH;
	// selections below 5 are not direction loads and fall to the unhandled flag
	assign is_dir  = insn[mie_pkg::TOP4_HI:mie_pkg::TOP9_LO] == mie_pkg::OPC_LOAD_DIR
		&& insn[mie_pkg::DSEL_W-1:0] >= mie_pkg::DSEL_MIN
		&& insn[mie_pkg::DSEL_W-1:0] <= mie_pkg::DSEL_MAX;
	assign dest    = insn[mie_pkg::DEST_BIT];
	assign sub_res = mie_sub(file_operand, st_r.acc);
	assign swp     = mie_swap(file_operand);

	always_comb begin
		st_nxt       = st_r;
		// write strobes are pulses of one enabled cycle
		st_nxt.fwe   = 1'b0;
		st_nxt.dwe   = 1'b0;
		st_nxt.unh   = 1'b0;
		if (insn_valid) begin
			if (is_lit) begin
				st_nxt.acc = insn[mie_pkg::LIT_HI:0];
			end else if (is_sub) begin
				st_nxt.c  = sub_res[DATA_W+2];
				st_nxt.dc = sub_res[DATA_W+1];
				st_nxt.z  = sub_res[DATA_W];
				if (dest == mie_pkg::DEST_ACC) begin
					st_nxt.acc = sub_res[DATA_W-1:0];
				end else begin
					st_nxt.fwe   = 1'b1;
					st_nxt.faddr = insn[mie_pkg::FADDR_W-1:0];
					st_nxt.fdata = sub_res[DATA_W-1:0];
				end
			end else if (is_swap) begin
				if (dest == mie_pkg::DEST_ACC) begin
					st_nxt.acc = swp;
				end else begin
					st_nxt.fwe   = 1'b1;
					st_nxt.faddr = insn[mie_pkg::FADDR_W-1:0];
					st_nxt.fdata = swp;
				end
			end else if (is_dir) begin
				st_nxt.dwe   = 1'b1;
				st_nxt.dsel  = insn[mie_pkg::DSEL_W-1:0];
				st_nxt.ddata = st_r.acc;
			end else begin
				st_nxt.unh = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= '0;
			st_r.acc   <= mie_pkg::ACC_RST;
			st_r.c     <= mie_pkg::FLAG_RST;
			st_r.dc    <= mie_pkg::FLAG_RST;
			st_r.z     <= mie_pkg::FLAG_RST;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign acc              = st_r.acc;
	assign flag_carry       = st_r.c;
	assign flag_digit_carry = st_r.dc;
	assign flag_zero        = st_r.z;
	assign file_wr_en       = st_r.fwe;
	assign file_wr_addr     = st_r.faddr;
	assign file_wr_data     = st_r.fdata;
	assign dir_wr_en        = st_r.dwe;
	assign dir_wr_sel       = st_r.dsel;
	assign dir_wr_data      = st_r.ddata;
	assign insn_unhandled   = st_r.unh;

	// checks; opcode checks fire only on cycles where the instruction is taken, the select check on any cycle, the enable and idle checks on untaken cycles
	logic take;
	assign take = clk_en && insn_valid;

	a_swap_acc_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_swap && dest == mie_pkg::DEST_ACC |=> acc == mie_swap($past(file_operand)) && !file_wr_en)
		else $error("nibble exchange to accumulator wrong");

	a_swap_file_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_swap && dest == mie_pkg::DEST_FILE |=> file_wr_en && file_wr_data == mie_swap($past(file_operand))
		&& file_wr_addr == $past(insn[mie_pkg::FADDR_W-1:0]) && $stable(acc))
		else $error("nibble exchange to file wrong");

	a_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && (is_swap || is_dir || is_lit) |=> $stable({flag_carry, flag_digit_carry, flag_zero}))
		else $error("flags changed on flagless opcode");

	a_dir_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_dir |=> dir_wr_en && dir_wr_data == $past(acc) && dir_wr_sel == $past(insn[mie_pkg::DSEL_W-1:0]))
		else $error("direction load wrong");

	a_dir_sel_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dir_wr_en |-> dir_wr_sel >= mie_pkg::DSEL_MIN)
		else $error("direction select out of range");

	a_sub_acc_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_sub && dest == mie_pkg::DEST_ACC |=> acc == DATA_W'($past(file_operand) - $past(acc)))
		else $error("subtract result wrong");

	a_sub_file_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_sub && dest == mie_pkg::DEST_FILE |=> file_wr_en && $stable(acc)
		&& file_wr_data == DATA_W'($past(file_operand) - $past(acc)))
		else $error("subtract to file wrong");

	a_sub_file_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_sub && dest == mie_pkg::DEST_FILE |=> file_wr_addr == $past(insn[mie_pkg::FADDR_W-1:0]))
		else $error("subtract file address wrong");

	a_sub_acc_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_sub && dest == mie_pkg::DEST_ACC |=> !file_wr_en && !dir_wr_en && !insn_unhandled)
		else $error("subtract to accumulator raised a strobe");

	a_dir_acc_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_dir |=> $stable(acc) && !file_wr_en && !insn_unhandled)
		else $error("direction load disturbed other state");

	a_sub_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_sub |=> flag_carry == ($past(file_operand) >= $past(acc))
		&& flag_zero == ($past(file_operand) == $past(acc))
		&& flag_digit_carry == ($past(file_operand[mie_pkg::NIB_LO:0]) >= $past(acc[mie_pkg::NIB_LO:0])))
		else $error("subtract flags wrong");

	a_lit_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && is_lit |=> acc == $past(insn[mie_pkg::LIT_HI:0]) && !file_wr_en && !dir_wr_en)
		else $error("literal load wrong");

	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!clk_en |=> $stable(acc) && $stable(file_wr_en) && $stable(flag_carry))
		else $error("state moved while disabled");

	a_freeze_strobes: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!clk_en |=> $stable(dir_wr_en) && $stable(insn_unhandled) && $stable(file_wr_data) && $stable(dir_wr_data))
		else $error("strobes moved while disabled");

	// a word outside the subset must raise only the unhandled pulse and leave the rest of the core untouched
	a_unhandled_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take && !(is_lit || is_sub || is_swap || is_dir) |=> insn_unhandled && !file_wr_en && !dir_wr_en
		&& $stable(acc) && $stable({flag_carry, flag_digit_carry, flag_zero}))
		else $error("unhandled word changed state");

	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !insn_valid |=> !file_wr_en && !dir_wr_en && !insn_unhandled && $stable(acc))
		else $error("state moved without an instruction");

	c_sub_borrow: cover property (@(posedge sys_clk) disable iff (!rst_n) take && is_sub ##1 !flag_carry);
	c_swap_file:  cover property (@(posedge sys_clk) disable iff (!rst_n) take && is_swap && dest ##1 file_wr_en);
	c_dir_load:   cover property (@(posedge sys_clk) disable iff (!rst_n) take && is_dir ##1 dir_wr_en);
	c_lit_then_sub: cover property (@(posedge sys_clk) disable iff (!rst_n) take && is_lit ##1 take && is_sub);
	c_freeze_strobe: cover property (@(posedge sys_clk) disable iff (!rst_n) !clk_en && dir_wr_en);
endmodule
`default_nettype wire

// file: rtl/mie_pkg.sv
// opcode patterns and field positions of the executed instruction subset
package mie_pkg;
	localparam int INSN_W  = 12;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 5;
	localparam int DSEL_W  = 3;
	// field positions inside the instruction word, and nibble bounds inside the data byte
	localparam int TOP4_HI  = 11;
	localparam int TOP4_LO  = 8;
	localparam int TOP6_LO  = 6;
	localparam int TOP9_LO  = 3;
	localparam int DEST_BIT = 5;
	localparam int LIT_HI   = 7;
	localparam int NIB_HI   = 7;
	localparam int NIB_MID  = 4;
	localparam int NIB_LO   = 3;
	// opcode values
	localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
	localparam logic [5:0] OPC_SUB_ACC  = 6'h02;
	localparam logic [5:0] OPC_NIB_EXCH = 6'h0E;
	localparam logic [8:0] OPC_LOAD_DIR = 9'h000;
	// valid direction register selections
	localparam logic [2:0] DSEL_MIN = 3'h5;
	localparam logic [2:0] DSEL_MAX = 3'h7;
	// destination encodings
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	// reset values
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic       FLAG_RST = 1'b0;
endpackage

// file: tb/tb_top.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [11:0] insn;
		logic [7:0]  opnd;
		logic [7:0]  acc;
		logic [2:0]  flg;
		logic [2:0]  stb;
		logic [7:0]  wdat;
	} mie_row_t;
	// flg is carry, digit carry, zero; stb is file write, direction write, unhandled
	localparam mie_row_t ROWS [13] = '{
		{12'hC02, 8'h00, 8'h02, 3'h0, 3'h0, 8'h00}, {12'h0A3, 8'h03, 8'h02, 3'h6, 3'h4, 8'h01},
		{12'h082, 8'h02, 8'h00, 3'h7, 3'h0, 8'h00}, {12'hCA5, 8'h00, 8'hA5, 3'h7, 3'h0, 8'h00},
		{12'h381, 8'hA5, 8'h5A, 3'h7, 3'h0, 8'h00}, {12'h3A4, 8'h3C, 8'h5A, 3'h7, 3'h4, 8'hC3},
		{12'h006, 8'h00, 8'h5A, 3'h7, 3'h2, 8'h5A}, {12'h085, 8'h01, 8'hA7, 3'h0, 3'h0, 8'h00},
		{12'h0A0, 8'h18, 8'hA7, 3'h2, 3'h4, 8'h71}, {12'h005, 8'h00, 8'hA7, 3'h2, 3'h2, 8'hA7},
		{12'h007, 8'h00, 8'hA7, 3'h2, 3'h2, 8'hA7}, {12'h000, 8'h00, 8'hA7, 3'h2, 3'h1, 8'h00},
		{12'h100, 8'hFF, 8'hA7, 3'h2, 3'h1, 8'h00}};
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        insn_valid = 1'b0;
	logic [11:0] insn = 12'h000;
	logic [7:0]  file_operand = 8'h00;
	logic [7:0]  acc;
	logic        flag_carry;
	logic        flag_digit_carry;
	logic        flag_zero;
	logic        file_wr_en;
	logic [4:0]  file_wr_addr;
	logic [7:0]  file_wr_data;
	logic        dir_wr_en;
	logic [2:0]  dir_wr_sel;
	logic [7:0]  dir_wr_data;
	logic        insn_unhandled;
	int          errors = 0;
	int          n_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	mie_exec i_mie_exec (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .insn_valid(insn_valid),
		.insn(insn), .file_operand(file_operand), .acc(acc), .flag_carry(flag_carry),
		.flag_digit_carry(flag_digit_carry), .flag_zero(flag_zero), .file_wr_en(file_wr_en),
		.file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .dir_wr_en(dir_wr_en),
		.dir_wr_sel(dir_wr_sel), .dir_wr_data(dir_wr_data), .insn_unhandled(insn_unhandled));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one instruction word held for one edge; outputs are sampled 1 ns after that edge
	task automatic step(input logic [11:0] i, input logic [7:0] o, input logic v);
		insn = i;
		file_operand = o;
		insn_valid = v;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic chk_state(input logic [7:0] a, input logic [2:0] f, input logic [2:0] s);
		chk("acc", a, acc);
		chk("flags", {5'h0, f}, {5'h0, flag_carry, flag_digit_carry, flag_zero});
		chk("strobes", {5'h0, s}, {5'h0, file_wr_en, dir_wr_en, insn_unhandled});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#50000;
		errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		@(posedge sys_clk);
		#1;
		chk_state(8'h00, 3'h0, 3'h0);
		$display("test reset done");
		// rows run back to back, each using the accumulator left by the one before
		foreach (ROWS[k]) begin
			step(ROWS[k].insn, ROWS[k].opnd, 1'b1);
			chk_state(ROWS[k].acc, ROWS[k].flg, ROWS[k].stb);
			if (ROWS[k].stb[2]) begin
				chk("file data", ROWS[k].wdat, file_wr_data);
				chk("file addr", {3'h0, ROWS[k].insn[4:0]}, {3'h0, file_wr_addr});
			end
			if (ROWS[k].stb[1]) begin
				chk("dir data", ROWS[k].wdat, dir_wr_data);
				chk("dir sel", {5'h0, ROWS[k].insn[2:0]}, {5'h0, dir_wr_sel});
			end
		end
		$display("test rows done");
		// invalid word must be ignored entirely
		step(12'hC33, 8'h00, 1'b0);
		chk_state(8'hA7, 3'h2, 3'h0);
		// frozen enable holds the strobe and refuses the load
		step(12'h006, 8'h00, 1'b1);
		clk_en = 1'b0;
		step(12'hC33, 8'h00, 1'b1);
		chk_state(8'hA7, 3'h2, 3'h2);
		clk_en = 1'b1;
		step(12'hC33, 8'h00, 1'b1);
		chk_state(8'h33, 3'h2, 3'h0);
		$display("test enable done");
		// reset in mid-run clears without a clock edge
		insn = 12'hC5A;
		rst_n = 1'b0;
		#1;
		chk_state(8'h00, 3'h0, 3'h0);
		@(posedge sys_clk);
		#1;
		chk_state(8'h00, 3'h0, 3'h0);
		// word presented across the release is taken at the first edge after it
		rst_n = 1'b1;
		@(posedge sys_clk);
		#1;
		chk_state(8'h5A, 3'h0, 3'h0);
		$display("test midrun reset done");
		stop_test();
	end
endmodule
`default_nettype wire
